/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [1:0] s;
    logic [15:0] e;
    logic [15:0] m;
  } ulmc_row_t;
  logic clk, rst_n, wr, rd, txs, arts_n, irqi, lbit, rxpin, rxs, txp, irtx, rirq, dsel;
  logic cts_n, dsr_n, ri_n, cd_n, dtr_n, rts_n, op2_n, irqo, oe, tick;
  logic sh, s2, pe, pev, pf, pfv, xon, ce;
  logic [3:0] adr, pins_n, wbits;
  logic [7:0] wd, rdat, rxl, txl;
  logic [6:0] cnt;
  logic [15:0] dv;
  int bad_count, checks_done, n;
  ulmc_row_t rows [] = '{
    '{4'h9, 8'h10, 2'd0, 16'h0000, 16'h0000},
    '{4'h8, 8'h00, 2'd0, 16'h0000, 16'h0000},
    '{4'h2, 8'h01, 2'd0, 16'h0101, 16'hFFFF},
    '{4'h2, 8'h41, 2'd0, 16'h0401, 16'hFFFF},
    '{4'h2, 8'h81, 2'd0, 16'h0801, 16'hFFFF},
    '{4'h2, 8'hC1, 2'd0, 16'h0E01, 16'hFFFF},
    '{4'h8, 8'h10, 2'd0, 16'h1C10, 16'hFFFF},
    '{4'h2, 8'h51, 2'd0, 16'h1008, 16'hFFFF},
    '{4'h2, 8'hA1, 2'd0, 16'h1818, 16'hFFFF},
    '{4'h2, 8'hF1, 2'd0, 16'h1C1E, 16'hFFFF},
    '{4'h2, 8'h00, 2'd0, 16'h1C1E, 16'hFFFF},
    '{4'h8, 8'h20, 2'd0, 16'h3C38, 16'hFFFF},
    '{4'h2, 8'h01, 2'd0, 16'h0808, 16'hFFFF},
    '{4'h2, 8'h51, 2'd0, 16'h1010, 16'hFFFF},
    '{4'h2, 8'hA1, 2'd0, 16'h3820, 16'hFFFF},
    '{4'h8, 8'h30, 2'd0, 16'h0101, 16'hFFFF},
    '{4'hA, 8'h25, 2'd0, 16'h2501, 16'hFFFF},
    '{4'h8, 8'hB0, 2'd0, 16'h2501, 16'hFFFF},
    '{4'hA, 8'h11, 2'd0, 16'h2511, 16'hFFFF},
    '{4'h2, 8'h01, 2'd0, 16'h2511, 16'hFFFF},
    '{4'h8, 8'h20, 2'd0, 16'h0000, 16'h0000},
    '{4'h2, 8'hA1, 2'd0, 16'h3820, 16'hFFFF},
    '{4'h9, 8'h00, 2'd0, 16'h0000, 16'h0000},
    '{4'h2, 8'hD1, 2'd0, 16'h3C20, 16'hFFFF},
    '{4'h3, 8'h04, 2'd1, 16'h0AC1, 16'h0FFD},
    '{4'h3, 8'h05, 2'd1, 16'h0B21, 16'h0FFD},
    '{4'h3, 8'h0A, 2'd1, 16'h0B91, 16'h0FFD},
    '{4'h3, 8'h1F, 2'd1, 16'h0C39, 16'h0FFD},
    '{4'h3, 8'h2B, 2'd1, 16'h0C17, 16'h0FFF},
    '{4'h3, 8'h3B, 2'd1, 16'h0C1D, 16'h0FFF},
    '{4'h3, 8'h43, 2'd1, 16'h0401, 16'h0FFD},
    '{4'h3, 8'h83, 2'd1, 16'h0C00, 16'h0FFD},
    '{4'h0, 8'h34, 2'd3, 16'h0000, 16'h0000},
    '{4'h1, 8'h12, 2'd3, 16'h1234, 16'hFFFF},
    '{4'h3, 8'h03, 2'd3, 16'h1234, 16'hFFFF},
    '{4'h0, 8'h55, 2'd3, 16'h1234, 16'hFFFF},
    '{4'h4, 8'h00, 2'd2, 16'h0072, 16'h007F},
    '{4'h4, 8'h01, 2'd2, 16'h0032, 16'h007F},
    '{4'h4, 8'h02, 2'd2, 16'h0052, 16'h007F},
    '{4'h4, 8'h08, 2'd2, 16'h006A, 16'h007F},
    '{4'h4, 8'h20, 2'd2, 16'h0076, 16'h007F},
    '{4'h4, 8'h40, 2'd2, 16'h0072, 16'h007F},
    '{4'h4, 8'h12, 2'd2, 16'h0072, 16'h007F}
  };

  ulmc_line_modem_control i_ulmc_line_modem_control (
    .CLOCK_IN(clk), .RSTN_IN(rst_n), .CE_IN(ce), .ADDR_IN(adr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .RX_COUNT_IN(cnt), .RX_LEVEL_OUT(rxl),
    .TX_LEVEL_OUT(txl), .RX_IRQ_OUT(rirq), .DATA_SEL_OUT(dsel), .WORD_BITS_OUT(wbits),
    .STOP_HALF_OUT(sh), .STOP_TWO_OUT(s2), .PARITY_EN_OUT(pe), .PARITY_EVEN_OUT(pev),
    .PARITY_FORCED_OUT(pf), .PARITY_FORCE_VAL_OUT(pfv), .XON_ANY_OUT(xon),
    .BAUD_TICK_OUT(tick), .DIVISOR_OUT(dv), .TX_SERIAL_IN(txs), .RX_PIN_IN(rxpin),
    .RX_SERIAL_OUT(rxs), .TX_PIN_OUT(txp), .IR_TX_OUT(irtx), .CTS_N_IN(cts_n),
    .DSR_N_IN(dsr_n), .RING_INDICATOR_IN_N_IN(ri_n), .CD_N_IN(cd_n), .AUTO_RTS_N_IN(arts_n),
    .IRQ_IN(irqi), .TERMINAL_READY_N_OUT(dtr_n), .REQUEST_TO_SEND_N_OUT(rts_n),
    .SPARE_OUTPUT_TWO_N_OUT(op2_n), .IRQ_OUT(irqo), .IRQ_OE_OUT(oe)
  );
  ulmc_line_partner i_ulmc_line_partner (
    .PINS_N_IN(pins_n), .LINE_IN(lbit), .RX_LINE_OUT(rxpin), .CTS_N_OUT(cts_n),
    .DSR_N_OUT(dsr_n), .RI_N_OUT(ri_n), .CD_N_OUT(cd_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input logic [1:0] s);
    case (s)
      2'd0: return {rxl, txl};
      2'd1: return {4'h0, txp, wbits, sh, s2, pe, pev, pf, pfv, dsel};
      2'd2: return {9'h000, dtr_n, rts_n, op2_n, oe, xon, txp, irtx};
      default: return dv;
    endcase
  endfunction
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g & m, e & m);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp({8'h00, rdat}, {8'h00, e}, {8'h00, m});
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {rst_n, wr, rd, irqi, arts_n, txs, lbit, adr, wd, cnt} = {4'h0, 3'b111, 4'h0, 8'h00, 7'h00};
    pins_n = 4'b1010;
    ce = 1'b1;
    reset_dut();
    // Framing is only rewritten while the line is idle
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      settle();
      if (rows[i].m !== 16'h0000) cmp(obs(rows[i].s), rows[i].e, rows[i].m);
    end
    $display("test table rows done");
    wr_reg(4'h4, 8'h1F);
    txs <= 1'b0;
    settle();
    cmp({14'h0000, rxs, txp}, 16'h0001, 16'hFFFF);
    rd_reg(4'h6, 8'hF0, 8'hF0);
    wr_reg(4'h4, 8'h40);
    settle();
    cmp({14'h0000, txp, irtx}, 16'h0003, 16'hFFFF);
    wr_reg(4'h4, 8'h00);
    txs <= 1'b1;
    lbit <= 1'b0;
    settle();
    cmp({13'h0000, rxs, txp, irtx}, 16'h0002, 16'hFFFF);
    rd_reg(4'h6, 8'h50, 8'hF0);
    $display("test loopback and infrared done");
    wr_reg(4'h9, 8'h40);
    wr_reg(4'h4, 8'h02);
    irqi <= 1'b1;
    settle();
    cmp({14'h0000, rts_n, irqo}, 16'h0003, 16'hFFFF);
    arts_n <= 1'b0;
    settle();
    cmp({14'h0000, rts_n, irqo}, 16'h0001, 16'hFFFF);
    $display("test auto flow control done");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr_reg(4'h4, 8'h80);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
        settle();
        n += int'(tick);
      end
      cmp(16'(n), (k == 1) ? 16'h0004 : 16'h0010, 16'hFFFF);
    end
    $display("test prescaler done");
    wr_reg(4'h9, 8'h10);
    wr_reg(4'h8, 8'h00);
    wr_reg(4'h2, 8'h81);
    cnt <= 7'h07;
    repeat (2) @(posedge clk);
    cnt <= 7'h08;
    #1;
    cmp({15'h0000, rirq}, 16'h0000, 16'hFFFF);
    settle();
    cmp({15'h0000, rirq}, 16'h0001, 16'hFFFF);
    rd_reg(4'hB, 8'h08, 8'hFF);
    rd_reg(4'hC, 8'h01, 8'hFF);
    rd_reg(4'hD, 8'h08, 8'hFF);
    rd_reg(4'h3, 8'h03, 8'hFF);
    rd_reg(4'h0, 8'h00, 8'hFF);
    rd_reg(4'h4, 8'h80, 8'hFF);
    rd_reg(4'h7, 8'h00, 8'hFF);
    $display("test receive level and reads done");
    @(posedge clk);
    reset_dut();
    settle();
    cmp(obs(2'd0), 16'h0101, 16'hFFFF);
    cmp(obs(2'd2), 16'h0072, 16'h007F);
    cmp(obs(2'd1), 16'h0A81, 16'h0FFD);
    rd_reg(4'h3, 8'h00, 8'hFF);
    rd_reg(4'h4, 8'h00, 8'hFF);
    $display("test reset done");
    ce <= 1'b0;
    wr_reg(4'h3, 8'h1F);
    ce <= 1'b1;
    rd_reg(4'h3, 8'h00, 8'hFF);
    $display("test clock enable done");
    wrap_up();
  end
endmodule

/* ulmc_line_modem_control.sv */
// Notes on behaviour
// - Receive interrupt raised when the receive count crosses the selected level.
// - Both directions share one table; latest selection governs both.
// - Feature control bits 5:4 pick table A, B, C or D.
// - Tables A, B, C give fixed receive levels per two-bit index; B and C also for transmit, A transmit is always 1.
// - Table D ignores FIFO bits; programmable level steered by feature bit 7.
// - Line control bits 1:0 set character length 5 to 8.
// - Bit 2 gives two stop bits, or one and a half for 5-bit characters.
// - Bit 3 enables parity generation and checking.
// - Bit 4 clear gives odd parity, set gives even parity.
// - Bit 5 forces parity to 1 when bit 4 clear, to 0 when set.
// - Bit 6 holds transmit output low outside loopback and infrared modes until software clears it.
// - Bit 7 steers data addresses to the divisor latch bytes.
// - Modem bit 0 set drives terminal-ready low outside loopback; clear drives it high.
// - Modem bit 1 drives request-to-send low outside loopback unless auto flow control owns it.
// - Modem bit 2 drives no pin; loopback shows it as ring indicator.
// - Modem bit 3 enables interrupt output and drives spare output two low.
// - Modem bit 4 selects internal local loopback.
// - Modem bit 5 lets any received character resume halted transmission.
// - Modem bit 6 routes serial data through infrared path outside loopback, idle low.
// - Modem bit 7 divides the baud clock source by four.
// - In loopback, clear-to-send mirrors request-to-send, data-set-ready mirrors terminal-ready.
// - Transmit trigger writable only with enhanced bit 4; FIFO writes need enable bit.
module ulmc_line_modem_control #(
  parameter int COUNT_WIDTH = 7
) (
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  // Register port
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // FIFO side
  input wire logic [COUNT_WIDTH-1:0] RX_COUNT_IN,
  output logic [7:0] RX_LEVEL_OUT,
  output logic [7:0] TX_LEVEL_OUT,
  output logic RX_IRQ_OUT,
  output logic DATA_SEL_OUT,
  // Framing to the serial engine
  output logic [3:0] WORD_BITS_OUT,
  output logic STOP_HALF_OUT,
  output logic STOP_TWO_OUT,
  output logic PARITY_EN_OUT,
  output logic PARITY_EVEN_OUT,
  output logic PARITY_FORCED_OUT,
  output logic PARITY_FORCE_VAL_OUT,
  output logic XON_ANY_OUT,
  output logic BAUD_TICK_OUT,
  output logic [15:0] DIVISOR_OUT,
  // Serial path
  input wire logic TX_SERIAL_IN,
  input wire logic RX_PIN_IN,
  output logic RX_SERIAL_OUT,
  output logic TX_PIN_OUT,
  output logic IR_TX_OUT,
  // Modem pins
  input wire logic CTS_N_IN,
  input wire logic DSR_N_IN,
  input wire logic RING_INDICATOR_IN_N_IN,
  input wire logic CD_N_IN,
  input wire logic AUTO_RTS_N_IN,
  input wire logic IRQ_IN,
  output logic TERMINAL_READY_N_OUT,
  output logic REQUEST_TO_SEND_N_OUT,
  output logic SPARE_OUTPUT_TWO_N_OUT,
  output logic IRQ_OUT,
  output logic IRQ_OE_OUT
);

  initial begin
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 8) begin
      $error("COUNT_WIDTH must be 1 to 8");
    end
  end

  ulmc_pkg::ulmc_state_t s_q;
  ulmc_pkg::ulmc_state_t s_d;
  ulmc_pkg::ulmc_bus_t bus;
  logic [7:0] line_ctl;
  logic [7:0] modem_ctl;
  logic loop_on;
  logic [3:0] modem_stat;
  logic [1:0] tsel;
  logic [1:0] rx_idx;
  logic [1:0] tx_idx;
  logic [7:0] rx_count8;
  logic [7:0] rx_lvl_sel;
  logic [7:0] tx_lvl_sel;

  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
  assign line_ctl = s_q.line_control;
  assign modem_ctl = s_q.modem_control;
  assign loop_on = modem_ctl[ulmc_pkg::MODEM_LOOP];
  assign rx_count8 = 8'(RX_COUNT_IN);

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger tables
  function automatic logic [7:0] rx_table(input logic [1:0] t, input logic [1:0] i);
    logic [7:0] v;
    v = 8'h01;
    unique case (t)
      ulmc_pkg::TABLE_A: v = (i == 2'h0) ? 8'h01 : (i == 2'h1) ? 8'h04 :
                             (i == 2'h2) ? 8'h08 : 8'h0E;
      ulmc_pkg::TABLE_B: v = (i == 2'h0) ? 8'h08 : (i == 2'h1) ? 8'h10 :
                             (i == 2'h2) ? 8'h18 : 8'h1C;
      ulmc_pkg::TABLE_C: v = (i == 2'h0) ? 8'h08 : (i == 2'h1) ? 8'h10 :
                             (i == 2'h2) ? 8'h38 : 8'h3C;
      ulmc_pkg::TABLE_D: v = 8'h01;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] tx_table(input logic [1:0] t, input logic [1:0] i);
    logic [7:0] v;
    v = 8'h01;
    unique case (t)
      ulmc_pkg::TABLE_A: v = 8'h01;
      ulmc_pkg::TABLE_B: v = (i == 2'h0) ? 8'h10 : (i == 2'h1) ? 8'h08 :
                             (i == 2'h2) ? 8'h18 : 8'h1E;
      ulmc_pkg::TABLE_C: v = (i == 2'h0) ? 8'h08 : (i == 2'h1) ? 8'h10 :
                             (i == 2'h2) ? 8'h20 : 8'h38;
      ulmc_pkg::TABLE_D: v = 8'h01;
    endcase
    return v;
  endfunction

  // Table D takes the programmable levels, others index the fixed tables
  assign tsel = s_q.feature_control[ulmc_pkg::FEAT_TABLE_LO +: 2];
  assign rx_idx = s_q.fifo_control[ulmc_pkg::FIFO_RX_LO +: 2];
  assign tx_idx = s_q.fifo_control[ulmc_pkg::FIFO_TX_LO +: 2];
  assign rx_lvl_sel = (tsel == ulmc_pkg::TABLE_D) ? s_q.prog_rx :
                      rx_table(tsel, rx_idx);
  assign tx_lvl_sel = (tsel == ulmc_pkg::TABLE_D) ? s_q.prog_tx :
                      tx_table(tsel, tx_idx);

  ////////////////////////////////////////////////////////////////////////////////
  // Modem status, loopback substitutes control bits for pins
  assign modem_stat = loop_on ?
    {modem_ctl[ulmc_pkg::MODEM_OUT2], modem_ctl[ulmc_pkg::MODEM_OUT1],
     modem_ctl[ulmc_pkg::MODEM_DTR], modem_ctl[ulmc_pkg::MODEM_RTS]} :
    ~s_q.modem_in_s2;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.modem_in_s1 = {CD_N_IN, RING_INDICATOR_IN_N_IN, DSR_N_IN, CTS_N_IN};
    s_d.modem_in_s2 = s_q.modem_in_s1;
    // Both directions follow one table choice
    s_d.rx_level = rx_lvl_sel;
    s_d.tx_level = tx_lvl_sel;
    if (bus.wr) begin
      unique case (bus.addr)
        ulmc_pkg::ADDR_DATA: begin
          if (line_ctl[ulmc_pkg::LINE_DIV_SEL]) begin
            s_d.divisor_low = bus.wdata;
          end
        end
        ulmc_pkg::ADDR_DIV_HIGH: begin
          if (line_ctl[ulmc_pkg::LINE_DIV_SEL]) begin
            s_d.divisor_high_byte = bus.wdata;
          end
        end
        ulmc_pkg::ADDR_FIFO_CONTROL: begin
          if (bus.wdata[ulmc_pkg::FIFO_ENABLE_BIT]) begin
            s_d.fifo_control[7:6] = bus.wdata[7:6];
            s_d.fifo_control[3:0] = bus.wdata[3:0];
            if (s_q.enhanced_feature[ulmc_pkg::ENH_ENABLE]) begin
              s_d.fifo_control[5:4] = bus.wdata[5:4];
            end
          end
        end
        ulmc_pkg::ADDR_LINE_CONTROL: s_d.line_control = bus.wdata;
        ulmc_pkg::ADDR_MODEM_CONTROL: s_d.modem_control = bus.wdata;
        ulmc_pkg::ADDR_FEATURE_CONTROL: s_d.feature_control = bus.wdata;
        ulmc_pkg::ADDR_ENHANCED_FEATURE: s_d.enhanced_feature = bus.wdata;
        ulmc_pkg::ADDR_PROG_TRIGGER: begin
          if (s_q.feature_control[ulmc_pkg::FEAT_PROG_DIR]) begin
            s_d.prog_tx = bus.wdata;
          end else begin
            s_d.prog_rx = bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // Read data stands for the single cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ulmc_pkg::ADDR_DATA: begin
          s_d.rdata = line_ctl[ulmc_pkg::LINE_DIV_SEL] ? s_q.divisor_low : 8'h00;
        end
        ulmc_pkg::ADDR_DIV_HIGH: begin
          s_d.rdata = line_ctl[ulmc_pkg::LINE_DIV_SEL] ? s_q.divisor_high_byte : 8'h00;
        end
        ulmc_pkg::ADDR_LINE_CONTROL: s_d.rdata = s_q.line_control;
        ulmc_pkg::ADDR_MODEM_CONTROL: s_d.rdata = s_q.modem_control;
        ulmc_pkg::ADDR_MODEM_STATUS: s_d.rdata = {modem_stat, 4'h0};
        ulmc_pkg::ADDR_FEATURE_CONTROL: s_d.rdata = s_q.feature_control;
        ulmc_pkg::ADDR_ENHANCED_FEATURE: s_d.rdata = s_q.enhanced_feature;
        ulmc_pkg::ADDR_PROG_TRIGGER: s_d.rdata = s_q.prog_rx;
        ulmc_pkg::ADDR_FORMAT_STATUS: s_d.rdata = s_q.rx_level;
        ulmc_pkg::ADDR_TRIGGER_STATUS: s_d.rdata = s_q.tx_level;
        ulmc_pkg::ADDR_RX_COUNT: s_d.rdata = rx_count8;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Receive interrupt on each upward crossing, held while above
    s_d.rx_above = rx_count8 >= s_q.rx_level;
    s_d.rx_irq = rx_count8 >= s_q.rx_level;
    // Prescaler produces one tick every one or four clocks
    s_d.baud_tick = 1'b0;
    if (modem_ctl[ulmc_pkg::MODEM_PRESCALE]) begin
      s_d.pre_cnt = s_q.pre_cnt + 2'h1;
      s_d.baud_tick = (s_q.pre_cnt == ulmc_pkg::PRESCALE_LAST);
    end else begin
      s_d.pre_cnt = 2'h0;
      s_d.baud_tick = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLOCK_IN) begin
    if (!RSTN_IN) begin
      s_q <= '0;
      s_q.line_control <= ulmc_pkg::RESET_ZERO;
      s_q.modem_control <= ulmc_pkg::RESET_ZERO;
      s_q.rx_level <= ulmc_pkg::RESET_LEVEL;
      s_q.tx_level <= ulmc_pkg::RESET_LEVEL;
      s_q.prog_rx <= ulmc_pkg::RESET_LEVEL;
      s_q.prog_tx <= ulmc_pkg::RESET_LEVEL;
      s_q.modem_in_s1 <= 4'hF;
      s_q.modem_in_s2 <= 4'hF;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign RDATA_OUT = s_q.rdata;
  assign RX_LEVEL_OUT = s_q.rx_level;
  assign TX_LEVEL_OUT = s_q.tx_level;
  assign RX_IRQ_OUT = s_q.rx_irq;
  assign DATA_SEL_OUT = ~line_ctl[ulmc_pkg::LINE_DIV_SEL];
  assign DIVISOR_OUT = {s_q.divisor_high_byte, s_q.divisor_low};
  assign WORD_BITS_OUT = 4'h5 + {2'h0, line_ctl[ulmc_pkg::LINE_WLEN_LO +: 2]};
  assign STOP_HALF_OUT = line_ctl[ulmc_pkg::LINE_STOP] && (line_ctl[1:0] == 2'h0);
  assign STOP_TWO_OUT = line_ctl[ulmc_pkg::LINE_STOP] && (line_ctl[1:0] != 2'h0);
  assign PARITY_EN_OUT = line_ctl[ulmc_pkg::LINE_PAR_EN];
  assign PARITY_EVEN_OUT = line_ctl[ulmc_pkg::LINE_PAR_EVEN];
  assign PARITY_FORCED_OUT = line_ctl[ulmc_pkg::LINE_PAR_EN] &&
    line_ctl[ulmc_pkg::LINE_PAR_FORCE];
  assign PARITY_FORCE_VAL_OUT = ~line_ctl[ulmc_pkg::LINE_PAR_EVEN];
  assign XON_ANY_OUT = modem_ctl[ulmc_pkg::MODEM_XON_ANY];
  assign BAUD_TICK_OUT = s_q.baud_tick;

  // Serial routing: loopback feeds transmit back, break forces space
  logic tx_line;
  assign tx_line = TX_SERIAL_IN && !line_ctl[ulmc_pkg::LINE_BREAK];
  assign RX_SERIAL_OUT = loop_on ? tx_line : RX_PIN_IN;
  assign TX_PIN_OUT = (loop_on || modem_ctl[ulmc_pkg::MODEM_IR]) ? 1'b1 : tx_line;
  assign IR_TX_OUT = (modem_ctl[ulmc_pkg::MODEM_IR] && !loop_on) ? ~tx_line : 1'b0;
  assign TERMINAL_READY_N_OUT = loop_on ? 1'b1 : ~modem_ctl[ulmc_pkg::MODEM_DTR];
  assign REQUEST_TO_SEND_N_OUT = loop_on ? 1'b1 :
    (s_q.enhanced_feature[ulmc_pkg::ENH_AUTO_RTS] ? AUTO_RTS_N_IN :
     ~modem_ctl[ulmc_pkg::MODEM_RTS]);
  assign SPARE_OUTPUT_TWO_N_OUT = ~modem_ctl[ulmc_pkg::MODEM_OUT2];
  assign IRQ_OUT = IRQ_IN;
  assign IRQ_OE_OUT = modem_ctl[ulmc_pkg::MODEM_OUT2];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_rx_irq;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && (rx_count8 >= s_q.rx_level) |=> RX_IRQ_OUT;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

  property p_table_a;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && tsel == 2'h0 && rx_idx == 2'h3 |=> s_q.rx_level == 8'h0E;
  endproperty
  a_table_a: assert property (p_table_a) else $error("table A level wrong");

  property p_table_c;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && tsel == 2'h2 && tx_idx == 2'h3 |=> s_q.tx_level == 8'h38;
  endproperty
  a_table_c: assert property (p_table_c) else $error("table C level wrong");

  property p_fcr_gate;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && WR_IN && ADDR_IN == ulmc_pkg::ADDR_FIFO_CONTROL && !WDATA_IN[0]
      |=> $stable(s_q.fifo_control);
  endproperty
  a_fcr_gate: assert property (p_fcr_gate) else $error("FIFO write not gated");

  property p_break;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      line_ctl[ulmc_pkg::LINE_BREAK] && !loop_on && !modem_ctl[ulmc_pkg::MODEM_IR]
      |-> !TX_PIN_OUT;
  endproperty
  a_break: assert property (p_break) else $error("break not low");

  property p_stop;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !(STOP_HALF_OUT && STOP_TWO_OUT) && (STOP_HALF_OUT -> WORD_BITS_OUT == 4'h5);
  endproperty
  a_stop: assert property (p_stop) else $error("stop length wrong");

  property p_loop_msr;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      loop_on |-> modem_stat[0] == modem_ctl[ulmc_pkg::MODEM_RTS] &&
        modem_stat[1] == modem_ctl[ulmc_pkg::MODEM_DTR];
  endproperty
  a_loop_msr: assert property (p_loop_msr) else $error("loopback status wrong");

  property p_prescale;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && BAUD_TICK_OUT && modem_ctl[ulmc_pkg::MODEM_PRESCALE] ##1 CE_IN &&
      modem_ctl[ulmc_pkg::MODEM_PRESCALE]
      |-> !BAUD_TICK_OUT;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale ticks too fast");

  property p_dlab_read;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && RD_IN && ADDR_IN == ulmc_pkg::ADDR_DATA && !line_ctl[ulmc_pkg::LINE_DIV_SEL]
      |=> RDATA_OUT == 8'h00;
  endproperty
  a_dlab_read: assert property (p_dlab_read) else $error("latch visible");

  property p_rx_irq_low;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && (rx_count8 < s_q.rx_level) |=> !RX_IRQ_OUT;
  endproperty
  a_rx_irq_low: assert property (p_rx_irq_low) else $error("rx irq early");

  property p_prog_rx;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      CE_IN && WR_IN && ADDR_IN == ulmc_pkg::ADDR_PROG_TRIGGER &&
      !s_q.feature_control[ulmc_pkg::FEAT_PROG_DIR] |=> s_q.prog_rx == $past(WDATA_IN);
  endproperty
  a_prog_rx: assert property (p_prog_rx) else $error("rx trigger not written");

  property p_dtr;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !loop_on |-> TERMINAL_READY_N_OUT == !modem_ctl[ulmc_pkg::MODEM_DTR];
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready wrong");

  property p_rts_auto;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !loop_on && s_q.enhanced_feature[ulmc_pkg::ENH_AUTO_RTS] |-> REQUEST_TO_SEND_N_OUT == AUTO_RTS_N_IN;
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("auto rts not routed");

  property p_out_two;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      IRQ_OE_OUT == modem_ctl[ulmc_pkg::MODEM_OUT2] && SPARE_OUTPUT_TWO_N_OUT == !IRQ_OE_OUT;
  endproperty
  a_out_two: assert property (p_out_two) else $error("output two wrong");

  property p_ir_idle;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      modem_ctl[ulmc_pkg::MODEM_IR] && !loop_on && tx_line |-> !IR_TX_OUT && TX_PIN_OUT;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared idle wrong");

  property p_loop_rx;
    @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      loop_on |-> RX_SERIAL_OUT == tx_line && TX_PIN_OUT;
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loopback path wrong");

endmodule

/* ulmc_line_partner.sv */
module ulmc_line_partner (
  // Commands from the bench
  input wire logic [3:0] PINS_N_IN,
  input wire logic LINE_IN,
  // Line and modem lines towards the device
  output logic RX_LINE_OUT,
  output logic CTS_N_OUT,
  output logic DSR_N_OUT,
  output logic RI_N_OUT,
  output logic CD_N_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // Far end holds its line and modem lines at the commanded static levels
  assign RX_LINE_OUT = LINE_IN;
  assign {CD_N_OUT, RI_N_OUT, DSR_N_OUT, CTS_N_OUT} = PINS_N_IN;
endmodule

/* ulmc_pkg.sv */
package ulmc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_DIV_HIGH = 4'h1;
  localparam logic [3:0] ADDR_FIFO_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_LINE_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_MODEM_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_MODEM_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FEATURE_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_ENHANCED_FEATURE = 4'h9;
  localparam logic [3:0] ADDR_PROG_TRIGGER = 4'hA;
  localparam logic [3:0] ADDR_FORMAT_STATUS = 4'hB;
  localparam logic [3:0] ADDR_TRIGGER_STATUS = 4'hC;
  localparam logic [3:0] ADDR_RX_COUNT = 4'hD;
  // Field positions
  localparam int FIFO_ENABLE_BIT = 0;
  localparam int FIFO_TX_LO = 4;
  localparam int FIFO_RX_LO = 6;
  localparam int FEAT_TABLE_LO = 4;
  localparam int FEAT_PROG_DIR = 7;
  localparam int ENH_ENABLE = 4;
  localparam int ENH_AUTO_RTS = 6;
  localparam int LINE_WLEN_LO = 0;
  localparam int LINE_STOP = 2;
  localparam int LINE_PAR_EN = 3;
  localparam int LINE_PAR_EVEN = 4;
  localparam int LINE_PAR_FORCE = 5;
  localparam int LINE_BREAK = 6;
  localparam int LINE_DIV_SEL = 7;
  localparam int MODEM_DTR = 0;
  localparam int MODEM_RTS = 1;
  localparam int MODEM_OUT1 = 2;
  localparam int MODEM_OUT2 = 3;
  localparam int MODEM_LOOP = 4;
  localparam int MODEM_XON_ANY = 5;
  localparam int MODEM_IR = 6;
  localparam int MODEM_PRESCALE = 7;
  // Reset values
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_LEVEL = 8'h01;
  // Table selects
  localparam logic [1:0] TABLE_A = 2'h0;
  localparam logic [1:0] TABLE_B = 2'h1;
  localparam logic [1:0] TABLE_C = 2'h2;
  localparam logic [1:0] TABLE_D = 2'h3;
  // Prescaler divide by four counter terminal value
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ulmc_bus_t;

  typedef struct packed {
    logic [7:0] fifo_control;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] feature_control;
    logic [7:0] enhanced_feature;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high_byte;
    logic [7:0] rx_level;
    logic [7:0] tx_level;
    logic [7:0] prog_rx;
    logic [7:0] prog_tx;
    logic [7:0] rdata;
    logic rx_above;
    logic rx_irq;
    logic [1:0] pre_cnt;
    logic baud_tick;
    logic [3:0] modem_in_s1;
    logic [3:0] modem_in_s2;
  } ulmc_state_t;
endpackage
